// >>> core/iba_cfg.svh
/*
 holds the address generator's constants: offsets, field positions, reset values, widths.
 assumes inclusion by bare name from the package and design files.
*/
// Function
// - indexed address: low plus offset, plus start if circular
// - indexed mode leaves pointer untouched
// - second word at first xor one
// - long read loads named then paired register
// - bitrev mode: address unmodified, then add offset
// - bitrev update uses reverse carry
// - circular bitrev: add start, pointer unchanged
// - post-add: address unmodified, plus start if circular, normal carry add
`ifndef IBA_CFG_SVH
`define IBA_CFG_SVH
`define IBA_PTR_W 23
`define IBA_LOW_W 16
`define IBA_OFF_W 16
`define IBA_DATA_W 16
`define IBA_REGS 8
`define IBA_REG_AW 3
`define IBA_PTR_RST 23'h000000
`define IBA_A_CTRL 12'h000
`define IBA_A_PTR0 12'h004
`define IBA_A_TOFF 12'h024
`define IBA_A_XOFF 12'h028
`define IBA_A_BSA 12'h02C
`define IBA_A_STAT 12'h030
`define IBA_A_DST 12'h034
`define IBA_A_MEM 12'h800
`define IBA_CTRL_COMPAT 0
`define IBA_CTRL_CIRC 8
`define IBA_MEM_DEPTH 256
`define IBA_MEM_AW 8
`endif

// >>> core/iba_pkg.sv
/*
 holds the shared types of the address generator.
 assumes the constants header sits beside it.
*/
`include "iba_cfg.svh"
package iba_pkg;
   typedef logic [`IBA_PTR_W-1:0] iba_ptr_t; // extended pointer
   typedef logic [`IBA_OFF_W-1:0] iba_off_t; // 16-bit offset
   typedef logic [1:0] iba_mode_t;
   // operand forms handled here
   localparam iba_mode_t IBA_M_INDEX = 2'h0;
   localparam iba_mode_t IBA_M_POSTADD = 2'h1;
   localparam iba_mode_t IBA_M_BITREV = 2'h2;
   // access state machine, one-hot
   typedef enum logic [3:0] {
      IBA_IDLE = 4'h1,
      IBA_RD1 = 4'h2,
      IBA_RD2 = 4'h4,
      IBA_DONE = 4'h8
   } iba_state_e;
endpackage

// >>> core/iba_agu_if.sv
/*
 holds the carrier between the controller and the address unit.
 assumes one clock domain; pure combinational signals.
*/
`timescale 1ns/1ps
interface iba_agu_if;
   import iba_pkg::*;
   iba_ptr_t ptr; // current extended pointer
   iba_off_t toff; // temporary offset
   iba_ptr_t xoff; // extended auxiliary offset
   iba_off_t bsa; // buffer start
   logic circ; // pointer in circular mode
   logic compat; // compatibility bit
   iba_mode_t mode; // operand form
   iba_ptr_t addr; // first address
   iba_ptr_t addr2; // second address
   iba_ptr_t ptr_next; // pointer after access
   modport ctl (output ptr, toff, xoff, bsa, circ, compat, mode, input addr, addr2, ptr_next);
   modport agu (input ptr, toff, xoff, bsa, circ, compat, mode, output addr, addr2, ptr_next);
endinterface

// >>> core/iba_agu.sv
/*
 holds the combinational address and pointer-update arithmetic.
 assumes its inputs are stable registered values.
*/
`timescale 1ns/1ps
`include "iba_cfg.svh"
module iba_agu (
   iba_agu_if.agu a
);
   import iba_pkg::*;

   // reverse-carry add over the low part; carries flow msb to lsb
   function automatic logic [`IBA_LOW_W-1:0] iba_rev_add(input logic [`IBA_LOW_W-1:0] x,
                                                        input logic [`IBA_LOW_W-1:0] y);
      logic c;
      logic [`IBA_LOW_W-1:0] s;
      c = 1'b0;
      s = '0;
      for (int i = `IBA_LOW_W-1; i >= 0; i--) begin
         s[i] = x[i] ^ y[i] ^ c;
         c = (x[i] & y[i]) | (c & (x[i] ^ y[i]));
      end
      return s;
   endfunction

   iba_ptr_t off; // selected offset
   iba_ptr_t base; // pointer with optional buffer start
   iba_ptr_t first; // generated first address

   always_comb begin
      // offset choice by compatibility bit
      off = a.compat ? a.xoff : iba_ptr_t'(a.toff);
      // high part kept, low part summed with start
      base = {a.ptr[`IBA_PTR_W-1:`IBA_LOW_W],
              a.ptr[`IBA_LOW_W-1:0] + (a.circ ? a.bsa : `IBA_OFF_W'h0000)};
      if (a.mode == IBA_M_INDEX) begin
         first = {base[`IBA_PTR_W-1:`IBA_LOW_W], base[`IBA_LOW_W-1:0] + off[`IBA_LOW_W-1:0]};
      end else begin
         first = base; // pointer, plus start if circular, as address
      end
      a.addr = first;
      a.addr2 = {first[`IBA_PTR_W-1:1], ~first[0]}; // even +1, odd -1
      case (a.mode)
         IBA_M_POSTADD: a.ptr_next = a.ptr + off; // normal carry
         IBA_M_BITREV: begin
            // circular pointer is not modified, stays in buffer
            if (a.circ) begin
               a.ptr_next = a.ptr;
            end else begin
               a.ptr_next = {a.ptr[`IBA_PTR_W-1:`IBA_LOW_W],
                             iba_rev_add(a.ptr[`IBA_LOW_W-1:0], off[`IBA_LOW_W-1:0])};
            end
         end
         default: a.ptr_next = a.ptr; // indexed: pointer unchanged
      endcase
   end
endmodule

// >>> core/iba_top.sv
/*
 holds the APB-reachable address generator: pointers, offsets, a small data memory,
 and the access sequencer with its destination register pair.
 assumes an APB master on pclk; one register per aligned word.
*/
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "iba_cfg.svh"
module iba_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic busy
);
   import iba_pkg::*;

   iba_agu_if ag ();
   iba_agu u_agu (.a(ag));

   logic [`IBA_DATA_W-1:0] mem [`IBA_MEM_DEPTH]; // data memory words
   iba_ptr_t ptr_reg [`IBA_REGS]; // extended_aux_pointer set
   iba_ptr_t ptr_next [`IBA_REGS];
   iba_off_t temp_offset_reg, temp_offset_next;
   iba_ptr_t extended_aux_offset_reg, extended_aux_offset_next;
   iba_off_t buffer_start_reg, buffer_start_next;
   logic [31:0] ctrl_reg, ctrl_next; // compat bit, circular enables
   logic [31:0] cmd_reg, cmd_next; // last issued command
   iba_ptr_t a1_reg, a1_next, a2_reg, a2_next; // latched addresses
   iba_ptr_t pn_reg, pn_next; // latched pointer update
   logic [`IBA_DATA_W-1:0] temp_dest_first_reg, temp_dest_first_next;
   logic [`IBA_DATA_W-1:0] temp_dest_second_reg, temp_dest_second_next;
   iba_state_e st_reg, st_next;
   logic [31:0] prdata_next;
   logic pready_next, pslverr_next;
   logic mem_we; // apb write to memory
   logic [`IBA_MEM_AW-1:0] mem_wa;

   // command word fields: pointer select, mode, long access
   logic [`IBA_REG_AW-1:0] sel;
   iba_mode_t mode;
   logic lng;
   assign sel = cmd_reg[2:0];
   assign mode = iba_mode_t'(cmd_reg[5:4]);
   assign lng = cmd_reg[8];

   // feed the address unit from the selected pointer
   assign ag.ptr = ptr_reg[sel];
   assign ag.toff = temp_offset_reg;
   assign ag.xoff = extended_aux_offset_reg;
   assign ag.bsa = buffer_start_reg;
   assign ag.circ = ctrl_reg[`IBA_CTRL_CIRC + sel];
   assign ag.compat = ctrl_reg[`IBA_CTRL_COMPAT];
   assign ag.mode = mode;

   function automatic logic [`IBA_MEM_AW-1:0] iba_mix(input iba_ptr_t x);
      return x[`IBA_MEM_AW-1:0]; // memory wraps on the low bits
   endfunction

   logic acc; // apb access phase
   assign acc = psel & penable;

   // next-state logic: apb decode and access sequencer
   always_comb begin
      for (int i = 0; i < `IBA_REGS; i++) begin
         ptr_next[i] = ptr_reg[i];
      end
      temp_offset_next = temp_offset_reg;
      extended_aux_offset_next = extended_aux_offset_reg;
      buffer_start_next = buffer_start_reg;
      ctrl_next = ctrl_reg;
      cmd_next = cmd_reg;
      a1_next = a1_reg;
      a2_next = a2_reg;
      pn_next = pn_reg;
      temp_dest_first_next = temp_dest_first_reg;
      temp_dest_second_next = temp_dest_second_reg;
      st_next = st_reg;
      prdata_next = prdata;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      mem_we = 1'b0;
      mem_wa = paddr[`IBA_MEM_AW+1:2];
      // one-cycle ready: answered in the second access cycle, one wait state
      if (acc && !pready) begin
         pready_next = 1'b1;
         prdata_next = 32'h00000000;
         if (paddr >= `IBA_A_MEM) begin
            // memory window, one word per address
            if (pwrite) begin
               mem_we = 1'b1;
            end else begin
               prdata_next = {16'h0000, mem[mem_wa]};
            end
         end else if (paddr >= `IBA_A_PTR0 && paddr < `IBA_A_TOFF) begin
            if (pwrite) begin
               ptr_next[3'(paddr[11:2] - 10'h001)] = pwdata[`IBA_PTR_W-1:0];
            end else begin
               prdata_next = {9'h000, ptr_reg[3'(paddr[11:2] - 10'h001)]};
            end
         end else begin
            case (paddr)
               `IBA_A_CTRL: begin
                  if (pwrite) begin
                     ctrl_next = pwdata;
                  end
                  prdata_next = ctrl_reg;
               end
               `IBA_A_TOFF: begin
                  if (pwrite) begin
                     temp_offset_next = pwdata[15:0];
                  end
                  prdata_next = {16'h0000, temp_offset_reg};
               end
               `IBA_A_XOFF: begin
                  if (pwrite) begin
                     extended_aux_offset_next = pwdata[`IBA_PTR_W-1:0];
                  end
                  prdata_next = {9'h000, extended_aux_offset_reg};
               end
               `IBA_A_BSA: begin
                  if (pwrite) begin
                     buffer_start_next = pwdata[15:0];
                  end
                  prdata_next = {16'h0000, buffer_start_reg};
               end
               `IBA_A_STAT: begin
                  // writing launches an access; refused while busy
                  if (pwrite) begin
                     if (st_reg == IBA_IDLE) begin
                        cmd_next = pwdata;
                        st_next = IBA_RD1;
                     end else begin
                        pslverr_next = 1'b1;
                     end
                  end
                  prdata_next = {9'h000, a1_reg};
               end
               `IBA_A_DST: begin
                  if (pwrite) begin
                     pslverr_next = 1'b1;
                  end
                  prdata_next = {temp_dest_second_reg, temp_dest_first_reg};
               end
               default: pslverr_next = 1'b1; // unmapped
            endcase
         end
      end
      // sequencer: address latch, reads, pointer writeback
      case (st_reg)
         IBA_IDLE: begin
            st_next = st_next;
         end
         IBA_RD1: begin
            a1_next = ag.addr;
            a2_next = ag.addr2;
            pn_next = ag.ptr_next;
            temp_dest_first_next = mem[iba_mix(ag.addr)]; // first word to named reg
            st_next = lng ? IBA_RD2 : IBA_DONE;
         end
         IBA_RD2: begin
            temp_dest_second_next = mem[iba_mix(a2_reg)]; // second word to pair reg
            st_next = IBA_DONE;
         end
         IBA_DONE: begin
            ptr_next[sel] = pn_reg; // indexed mode writes back the same value
            st_next = IBA_IDLE;
         end
         default: st_next = IBA_IDLE;
      endcase
   end

   // register all state except the data memory
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `IBA_REGS; i++) begin
            ptr_reg[i] <= `IBA_PTR_RST;
         end
         temp_offset_reg <= 16'h0000;
         extended_aux_offset_reg <= `IBA_PTR_RST;
         buffer_start_reg <= 16'h0000;
         ctrl_reg <= 32'h00000000;
         cmd_reg <= 32'h00000000;
         a1_reg <= `IBA_PTR_RST;
         a2_reg <= `IBA_PTR_RST;
         pn_reg <= `IBA_PTR_RST;
         temp_dest_first_reg <= 16'h0000;
         temp_dest_second_reg <= 16'h0000;
         st_reg <= IBA_IDLE;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         busy <= 1'b0;
      end else begin
         for (int i = 0; i < `IBA_REGS; i++) begin
            ptr_reg[i] <= ptr_next[i];
         end
         temp_offset_reg <= temp_offset_next;
         extended_aux_offset_reg <= extended_aux_offset_next;
         buffer_start_reg <= buffer_start_next;
         ctrl_reg <= ctrl_next;
         cmd_reg <= cmd_next;
         a1_reg <= a1_next;
         a2_reg <= a2_next;
         pn_reg <= pn_next;
         temp_dest_first_reg <= temp_dest_first_next;
         temp_dest_second_reg <= temp_dest_second_next;
         st_reg <= st_next;
         prdata <= prdata_next;
         pready <= pready_next;
         pslverr <= pslverr_next;
         busy <= (st_next != IBA_IDLE);
      end
   end

   // memory has no reset; contents come from software
   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem[mem_wa] <= pwdata[15:0];
      end
   end
endmodule

// >>> verif/iba_top_assertions.sv
/*
 checker for the address generator's apb port.
 assumes it is bound onto iba_top, one clock, async low reset.
*/
`timescale 1ns/1ps
`include "iba_cfg.svh"
module iba_top_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic busy
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // access phase still waiting for its answer
   sequence s_acc;
      psel && penable && !pready;
   endsequence
   // command write at the edge that takes it, before its answer
   sequence s_cmd;
      psel && penable && !pready && pwrite && paddr == `IBA_A_STAT;
   endsequence
   chk_ready_one_wait: assert property (s_acc |=> pready) else $error("answer late");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   chk_ready_req: assert property (pready |-> psel && penable) else $error("stray ready");
   chk_err_ready: assert property (pslverr |-> pready) else $error("stray error");
   chk_hole_zero: assert property (pready && !pwrite && paddr >= 12'h038 && paddr < 12'h800
      |-> pslverr && prdata == 32'h0) else $error("hole read not refused");
   chk_result_ro: assert property (pready && pwrite && paddr == `IBA_A_DST |-> pslverr)
      else $error("result write accepted");
   chk_cmd_start: assert property ((s_cmd and !busy) |=> busy)
      else $error("command did not start");
   chk_busy_end: assert property ($rose(busy) |-> ##[1:8] !busy) else $error("busy stuck");
   chk_cmd_refused: assert property ((s_cmd and busy) |=> pslverr)
      else $error("busy command taken");
endmodule

// >>> verif/iba_apb_host.sv
/*
 apb master standing in for the software side.
 assumes pready comes back on its own; a hang raises hung.
*/
`timescale 1ns/1ps
module iba_apb_host (
   input wire logic pclk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic hung
);
   logic keep; // next setup follows the last answer with no idle cycle
   // idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      hung = 1'b0;
      keep = 1'b0;
   end
   // one transfer; request held until pready is sampled high
   // nxt keeps psel up so the next setup starts at the answering edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e, input logic nxt);
      int n;
      n = 0;
      if (!keep) begin
         @(posedge pclk);
      end
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) hung <= 1'b1; // bounded wait ran out
      r = prdata;
      e = pslverr;
      if (!nxt) begin
         psel <= 1'b0;
      end
      penable <= 1'b0;
      keep = nxt;
   endtask
endmodule

// >>> verif/tb.sv
/*
 self-checking bench: random pointers, offsets and memory against an integer model.
 assumes the host model drives every apb input.
*/
`timescale 1ns/1ps
`include "iba_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, busy, hung, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int mem[256]; // model memory, 16-bit words
   int seed = 68235;
   int miscompares = 0;
   int n_tests = 0;
   always #4 pclk = ~pclk;
   iba_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busy(busy));
   iba_apb_host u_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .hung(hung));
   // bit mirror of a 16-bit field; reverse carry is a normal add between mirrors
   function automatic int rev16(int v);
      int r = 0;
      for (int i = 0; i < 16; i++) r |= ((v >> i) & 1) << (15 - i);
      return r;
   endfunction
   task automatic finish_test;
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input int d);
      u_host.xfer(1'b1, a, 32'(d), rd, er, 1'b0);
   endtask
   task automatic rdv(input logic [11:0] a);
      u_host.xfer(1'b0, a, 32'h0, rd, er, 1'b0);
   endtask
   // wait for busy to reach v, bounded
   task automatic wait_busy(input logic v, input int lim);
      int n;
      n = 0;
      while (busy !== v && n < lim) begin
         @(posedge pclk);
         n++;
      end
      if (busy !== v) begin
         miscompares++;
         finish_test;
      end
   endtask
   always @(posedge hung) begin
      miscompares++;
      finish_test;
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 256; i++) begin
         mem[i] = $random(seed) & 16'hFFFF;
         wr(`IBA_A_MEM + 12'(4 * i), mem[i]);
      end
      // every mode, offset source, width and circular setting
      for (int t = 0; t < 24; t++) begin
         int c, lg, m, cr, k, p, tf, xf, bs, off, a, np, ev;
         c = t % 2;
         lg = (t / 2) % 2;
         m = t / 8;
         cr = ((t / 4) % 2) & (m != 1); // circular post-add is out of scope
         k = t % 8;
         p = $random(seed) & 23'h7FFFFF;
         tf = $random(seed) & 16'hFFFF;
         xf = $random(seed) & 23'h7FFFFF;
         bs = $random(seed) & 16'hFFFF;
         wr(`IBA_A_CTRL, c | (cr << (8 + k)));
         wr(`IBA_A_PTR0 + 12'(4 * k), p);
         wr(`IBA_A_TOFF, tf);
         wr(`IBA_A_XOFF, xf);
         wr(`IBA_A_BSA, bs);
         wr(`IBA_A_STAT, k | (m << 4) | (lg << 8));
         wait_busy(1'b1, 4);
         wait_busy(1'b0, 32);
         off = c ? (xf & 16'hFFFF) : tf;
         a = (p & 23'h7F0000) | (((cr ? bs : 0) + p + (m == 0 ? off : 0)) & 16'hFFFF);
         np = p;
         if (m == 1) np = (p + (c ? xf : tf)) & 23'h7FFFFF;
         // bitrev updates only a non-circular pointer; a circular one keeps p
         if (m == 2 && cr == 0) np = (p & 23'h7F0000) | rev16(rev16(p) + rev16(off));
         rdv(`IBA_A_STAT);
         `CHK(rd, 32'(a))
         rdv(`IBA_A_DST);
         ev = mem[a & 255] | (lg ? mem[(a ^ 1) & 255] << 16 : 0);
         `CHK(lg ? rd : rd & 32'h0000FFFF, 32'(ev))
         rdv(`IBA_A_PTR0 + 12'(4 * k));
         `CHK(rd, 32'(np))
         $display("test %0d done", t);
      end
      // refusals: command during a long access, hole read, result write
      wr(`IBA_A_CTRL, 0);
      wr(`IBA_A_TOFF, 0);
      wr(`IBA_A_PTR0, 'h1234);
      wr(`IBA_A_PTR0 + 12'h004, 'h5678);
      // second command set up at the first one's answer lands while busy
      u_host.xfer(1'b1, `IBA_A_STAT, 32'h00000100, rd, er, 1'b1);
      `CHK(er, 1'b0)
      u_host.xfer(1'b1, `IBA_A_STAT, 32'h00000101, rd, er, 1'b0);
      `CHK(er, 1'b1)
      wait_busy(1'b0, 32);
      rdv(`IBA_A_STAT);
      `CHK(rd, 32'h00001234)
      rdv(12'h040);
      `CHK({er, rd}, {1'b1, 32'h0})
      wr(`IBA_A_DST, 1);
      `CHK(er, 1'b1)
      $display("test refusals done");
      finish_test;
   end
endmodule
bind iba_top iba_top_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .busy(busy));
